// File: logic/tva_pkg.sv
package tva_pkg;
   // ==============================================
   // sizes
   localparam int NALM   = 3;
   localparam int PCT_W  = 8;
   localparam int VOTE_W = 8;
   localparam int SUM_W  = 12;
   localparam int NRELAY = 4;
   localparam int POST_W = 16;
   // ==============================================
   // register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_WEIGHT = 12'h004;
   localparam logic [11:0] OFS_KEYV   = 12'h008;
   localparam logic [11:0] OFS_EXTV   = 12'h00c;
   localparam logic [11:0] OFS_POST   = 12'h010;
   localparam logic [11:0] OFS_RSEL   = 12'h014;
   localparam logic [11:0] OFS_STAT   = 12'h018;
   localparam logic [11:0] OFS_ISTAT  = 12'h01c;
   localparam logic [11:0] OFS_IMASK  = 12'h020;
   localparam logic [11:0] OFS_CH0    = 12'h040;
   localparam int          CH_STRIDE  = 16;
   // ==============================================
   // field positions
   localparam int CTRL_EN    = 0;
   localparam int CTRL_BLOCK = 1;
   localparam int CTRL_KBD   = 2;
   localparam int INT_START  = 0;
   localparam int INT_END    = 1;
   localparam int INT_ALARM  = 2;
   localparam int ST_SYS     = 8;
   localparam int ST_REC     = 9;
   localparam int ST_ALM     = 10;
   localparam int ST_TOTAL   = 16;
   // ==============================================
   // reset values
   localparam logic [PCT_W-1:0]  TRIG_PCT_RST = 8'h02;
   localparam logic [PCT_W-1:0]  DET_PCT_RST  = 8'h02;
   localparam logic [VOTE_W-1:0] CH_VOTE_RST  = 8'h01;
   localparam logic [VOTE_W-1:0] WEIGHT_RST   = 8'h01;
   localparam logic [VOTE_W-1:0] KEYV_RST     = 8'h01;
   localparam logic [VOTE_W-1:0] EXTV_RST     = 8'h00;
   localparam logic [POST_W-1:0] POST_RST     = 16'h03e8;
   localparam logic [5:0]        RSEL_RST     = 6'h24;
   localparam logic [2:0]        CTRL_RST     = 3'h1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TRIG = 2'b01,
      ST_POST = 2'b10
   } tva_rec_type;

   function automatic logic signed [SUM_W-1:0] vext(
      input logic [VOTE_W-1:0] v);
      return {{(SUM_W-VOTE_W){v[VOTE_W-1]}}, v};
   endfunction

   // level scaled by 100 so percent thresholds compare in integers
   function automatic logic [47:0] lvl_pct(input logic [31:0] m);
      return 48'(m) * 48'd100;
   endfunction

   function automatic logic [47:0] fs_pct(input logic [PCT_W-1:0] p,
                                          input int sw);
      return 48'(p) << (sw - 1);
   endfunction
endpackage

// File: logic/tva_link_if.sv
`timescale 1ns/1ps
interface tva_link_if #(parameter int NCH = 3);
   import tva_pkg::*;
   logic [NCH-1:0]          trig;
   logic [NALM-1:0]         alarm;
   logic signed [SUM_W-1:0] total;
   logic                    sys_trig;
   modport det  (output trig, output alarm);
   modport vote (input trig, output total, output sys_trig);
   modport ctl  (input trig, input alarm, input total, input sys_trig);
endinterface

// File: logic/tva_det.sv
`timescale 1ns/1ps
module tva_det import tva_pkg::*; #(
   parameter int NCH = 3,
   parameter int SW  = 24
) (
   // clock
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire logic                      ce,
   // samples and settings
   input wire logic                      en,
   input wire logic                      valid,
   input wire logic [NCH*SW-1:0]         data,
   input wire logic [NCH*PCT_W-1:0]      trig_pct,
   input wire logic [NCH*PCT_W-1:0]      det_pct,
   input wire logic [NCH*NALM*PCT_W-1:0] alm_pct,
   // results
   tva_link_if.det                       lk
);
   typedef struct packed {
      logic [NCH-1:0]  trig;
      logic [NALM-1:0] alarm;
   } tva_det_type;
   tva_det_type det_reg, det_next;

   function automatic logic [31:0] mag(input logic [SW-1:0] s);
      logic [SW:0] e;
      e = {s[SW-1], s};
      if (s[SW-1]) begin
         e = -e;
      end
      return 32'(e);
   endfunction

   always_comb begin
      logic [47:0] lvl;
      lvl = '0;
      det_next = det_reg;
      if (!en) begin
         det_next = '0;
      end else if (valid) begin
         det_next.alarm = '0;
         for (int c = 0; c < NCH; c++) begin
            lvl = lvl_pct(mag(data[c*SW +: SW]));
            if (!det_reg.trig[c] &&
                lvl >= fs_pct(trig_pct[c*PCT_W +: PCT_W], SW)) begin
               det_next.trig[c] = 1'b1;
            end else if (det_reg.trig[c] &&
                lvl < fs_pct(det_pct[c*PCT_W +: PCT_W], SW)) begin
               det_next.trig[c] = 1'b0;
            end
            for (int k = 0; k < NALM; k++) begin
               if (alm_pct[(c*NALM+k)*PCT_W +: PCT_W] != '0 &&
                   lvl > fs_pct(alm_pct[(c*NALM+k)*PCT_W +: PCT_W],
                                SW)) begin
                  det_next.alarm[k] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         det_reg <= '0;
      end else if (ce) begin
         det_reg <= det_next;
      end
   end

   assign lk.trig  = det_reg.trig;
   assign lk.alarm = det_reg.alarm;

   // ==============================================
   // checks on channel 0
   logic [47:0] lvl0;
   assign lvl0 = lvl_pct(mag(data[SW-1:0]));

   a_trig_reach: assert property (@(posedge clk) disable iff (!rst_n)
      ce && en && valid && !lk.trig[0] &&
      lvl0 >= fs_pct(trig_pct[PCT_W-1:0], SW) |=> lk.trig[0])
      else $error("channel did not trigger at threshold");
   a_detrig_hold: assert property (@(posedge clk) disable iff (!rst_n)
      ce && en && valid && lk.trig[0] &&
      lvl0 >= fs_pct(det_pct[PCT_W-1:0], SW) |=> lk.trig[0])
      else $error("channel left trigger above detrigger level");
   a_alarm_over: assert property (@(posedge clk) disable iff (!rst_n)
      ce && en && valid && alm_pct[PCT_W-1:0] != '0 &&
      lvl0 > fs_pct(alm_pct[PCT_W-1:0], SW) |=> lk.alarm[0])
      else $error("alarm not raised above alarm level");
endmodule

// File: logic/tva_vote.sv
`timescale 1ns/1ps
module tva_vote import tva_pkg::*; #(
   parameter int NCH = 3
) (
   // clock
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire logic                   ce,
   // vote settings and extra sources
   input wire logic [NCH*VOTE_W-1:0]  ch_vote,
   input wire logic [VOTE_W-1:0]      key_vote,
   input wire logic [VOTE_W-1:0]      ext_vote,
   input wire logic [VOTE_W-1:0]      weight,
   input wire logic                   key_on,
   input wire logic                   ext_on,
   // trigger state in, decision out
   tva_link_if.vote                   lk
);
   typedef struct packed {
      logic signed [SUM_W-1:0] total;
      logic                    sys;
   } tva_vote_type;
   tva_vote_type vote_reg, vote_next;
   logic signed [SUM_W-1:0] sum;
   logic signed [SUM_W-1:0] wgt;

   assign wgt = vext(weight);

   always_comb begin
      sum = '0;
      for (int c = 0; c < NCH; c++) begin
         if (lk.trig[c]) begin
            sum = sum + vext(ch_vote[c*VOTE_W +: VOTE_W]);
         end
      end
      if (key_on) begin
         sum = sum + vext(key_vote);
      end
      if (ext_on) begin
         sum = sum + vext(ext_vote);
      end
      vote_next.total = sum;
      vote_next.sys   = sum >= vext(weight);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vote_reg <= '0;
      end else if (ce) begin
         vote_reg <= vote_next;
      end
   end

   assign lk.total    = vote_reg.total;
   assign lk.sys_trig = vote_reg.sys;

   a_key_alone: assert property (@(posedge clk) disable iff (!rst_n)
      ce && key_on && !ext_on && lk.trig == '0 &&
      key_vote == weight |=> lk.sys_trig)
      else $error("keyboard vote alone did not trigger");
   a_sum_weight: assert property (@(posedge clk) disable iff (!rst_n)
      ce |=> lk.sys_trig == ($past(sum) >= $past(wgt)))
      else $error("system trigger disagrees with vote total");
endmodule

// File: logic/tva_top.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module tva_top import tva_pkg::*; #(
   parameter int NCH = 3,
   parameter int SW  = 24
) (
   // clock and reset
   input  wire logic              CLOCK,
   input  wire logic              RST_N,
   input  wire logic              CE,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // filtered trigger samples
   input  wire logic [NCH*SW-1:0] TRIG_DATA,
   input  wire logic              DATA_VALID,
   input  wire logic              EXT_TRIG,
   // event outputs
   output logic                   SYS_TRIG,
   output logic                   RECORDING,
   output logic                   EVENT_START,
   output logic      [NCH-1:0]    CHAN_TRIG,
   // alarm outputs
   output logic      [NRELAY-1:0] RELAY,
   output logic                   STAT_PKT,
   output logic      [NALM-1:0]   PKT_ALARM,
   // interrupt
   output logic                   IRQ
);
   localparam int NA = NCH * NALM;

   typedef struct packed {
      logic [2:0]               ctrl;
      logic [VOTE_W-1:0]        weight;
      logic [VOTE_W-1:0]        key_vote;
      logic [VOTE_W-1:0]        ext_vote;
      logic [POST_W-1:0]        post_len;
      logic [2*NALM-1:0]        rsel;
      logic [NCH*PCT_W-1:0]     trig_pct;
      logic [NCH*PCT_W-1:0]     det_pct;
      logic [NCH*VOTE_W-1:0]    ch_vote;
      logic [NA*PCT_W-1:0]      alm_pct;
      logic [2:0]               istat;
      logic [2:0]               imask;
      tva_rec_type              st;
      logic [POST_W-1:0]        post_cnt;
      logic [NALM-1:0]          alarm_d;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic                     sys_o;
      logic                     rec_o;
      logic                     start_o;
      logic [NCH-1:0]           chan_o;
      logic [NRELAY-1:0]        relay_o;
      logic                     pkt_o;
      logic [NALM-1:0]          pkt_alarm;
      logic                     irq_o;
   } tva_top_type;

   tva_top_type top_reg, top_next;

   tva_link_if #(.NCH(NCH)) lk ();

   // ==============================================
   // sub blocks
   tva_det #(.NCH(NCH), .SW(SW)) u_det (
      .clk      (CLOCK),
      .rst_n    (RST_N),
      .ce       (CE),
      .en       (top_reg.ctrl[CTRL_EN]),
      .valid    (DATA_VALID),
      .data     (TRIG_DATA),
      .trig_pct (top_reg.trig_pct),
      .det_pct  (top_reg.det_pct),
      .alm_pct  (top_reg.alm_pct),
      .lk       (lk.det)
   );

   tva_vote #(.NCH(NCH)) u_vote (
      .clk      (CLOCK),
      .rst_n    (RST_N),
      .ce       (CE),
      .ch_vote  (top_reg.ch_vote),
      .key_vote (top_reg.key_vote),
      .ext_vote (top_reg.ext_vote),
      .weight   (top_reg.weight),
      .key_on   (top_reg.ctrl[CTRL_KBD]),
      .ext_on   (EXT_TRIG),
      .lk       (lk.vote)
   );

   // ==============================================
   // apb decode helpers
   function automatic logic ch_hit(input logic [11:0] a);
      return a >= OFS_CH0 &&
             a < OFS_CH0 + 12'(NCH * CH_STRIDE) &&
             a[3:2] != 2'b11;
   endfunction

   function automatic int ch_idx(input logic [11:0] a);
      return int'((a - OFS_CH0) >> 4);
   endfunction

   // ==============================================
   // next state
   always_comb begin
      logic             acc;
      logic             wr;
      logic [31:0]      rd;
      logic             bad;
      logic [2:0]       ev;
      logic [NALM-1:0]  rise;
      int               c;
      acc  = PSEL && PENABLE;
      wr   = acc && top_reg.pready && PWRITE;
      rd   = '0;
      bad  = 1'b0;
      ev   = '0;
      rise = '0;
      c    = ch_idx(PADDR);
      top_next = top_reg;

      // ----- register reads, answered one cycle into access
      case (PADDR)
         OFS_CTRL:   rd = 32'(top_reg.ctrl);
         OFS_WEIGHT: rd = 32'(top_reg.weight);
         OFS_KEYV:   rd = 32'(top_reg.key_vote);
         OFS_EXTV:   rd = 32'(top_reg.ext_vote);
         OFS_POST:   rd = 32'(top_reg.post_len);
         OFS_RSEL:   rd = 32'(top_reg.rsel);
         OFS_STAT: begin
            rd[NCH-1:0]              = lk.trig;
            rd[ST_SYS]               = lk.sys_trig;
            rd[ST_REC]               = top_reg.rec_o;
            rd[ST_ALM +: NALM]       = lk.alarm;
            rd[ST_TOTAL +: 16]       = 16'(signed'(lk.total));
         end
         OFS_ISTAT:  rd = 32'(top_reg.istat);
         OFS_IMASK:  rd = 32'(top_reg.imask);
         default: begin
            if (ch_hit(PADDR)) begin
               case (PADDR[3:2])
                  2'b00: rd = 32'({
                     top_reg.det_pct[c*PCT_W +: PCT_W],
                     top_reg.trig_pct[c*PCT_W +: PCT_W]});
                  2'b01: rd =
                     32'(top_reg.ch_vote[c*VOTE_W +: VOTE_W]);
                  default: rd =
                     32'(top_reg.alm_pct[c*NALM*PCT_W +: NALM*PCT_W]);
               endcase
            end else begin
               bad = 1'b1;
            end
         end
      endcase

      top_next.pready  = acc && !top_reg.pready;
      if (acc && !top_reg.pready) begin
         top_next.prdata  = PWRITE ? 32'h0 : rd;
         top_next.pslverr = bad;
      end else begin
         top_next.pslverr = 1'b0;
      end

      // ----- register writes, on the edge that completes access
      if (wr) begin
         case (PADDR)
            OFS_CTRL:   top_next.ctrl     = PWDATA[2:0];
            OFS_WEIGHT: top_next.weight   = PWDATA[VOTE_W-1:0];
            OFS_KEYV:   top_next.key_vote = PWDATA[VOTE_W-1:0];
            OFS_EXTV:   top_next.ext_vote = PWDATA[VOTE_W-1:0];
            OFS_POST:   top_next.post_len = PWDATA[POST_W-1:0];
            OFS_RSEL:   top_next.rsel     = PWDATA[2*NALM-1:0];
            OFS_IMASK:  top_next.imask    = PWDATA[2:0];
            default: begin
               if (ch_hit(PADDR)) begin
                  case (PADDR[3:2])
                     2'b00: begin
                        top_next.trig_pct[c*PCT_W +: PCT_W] =
                           PWDATA[7:0];
                        top_next.det_pct[c*PCT_W +: PCT_W] =
                           PWDATA[15:8];
                     end
                     2'b01: top_next.ch_vote[c*VOTE_W +: VOTE_W] =
                        PWDATA[VOTE_W-1:0];
                     default:
                        top_next.alm_pct[c*NALM*PCT_W +: NALM*PCT_W] =
                           PWDATA[NALM*PCT_W-1:0];
                  endcase
               end
            end
         endcase
      end

      // ----- recording sequence
      case (top_reg.st)
         ST_IDLE: begin
            if (lk.sys_trig) begin
               top_next.st = ST_TRIG;
               ev[INT_START] = 1'b1;
            end
         end
         ST_TRIG: begin
            if (!lk.sys_trig) begin
               top_next.st       = ST_POST;
               top_next.post_cnt = top_reg.post_len;
            end
         end
         ST_POST: begin
            if (lk.sys_trig) begin
               top_next.st = ST_TRIG;
            end else if (top_reg.post_cnt == '0) begin
               top_next.st = ST_IDLE;
               ev[INT_END] = 1'b1;
            end else if (DATA_VALID) begin
               top_next.post_cnt = top_reg.post_cnt - 1'b1;
            end
         end
         default: top_next.st = ST_IDLE;
      endcase

      // ----- alarms to relays and status packet
      rise = lk.alarm & ~top_reg.alarm_d;
      top_next.alarm_d = lk.alarm;
      ev[INT_ALARM] = |rise;
      for (int r = 0; r < NRELAY; r++) begin
         top_next.relay_o[r] = 1'b0;
         for (int k = 0; k < NALM; k++) begin
            if (lk.alarm[k] && 32'(top_reg.rsel[2*k +: 2]) == r) begin
               top_next.relay_o[r] = 1'b1;
            end
         end
      end
      top_next.pkt_o = top_reg.ctrl[CTRL_BLOCK] && |rise;
      if (top_next.pkt_o) begin
         top_next.pkt_alarm = lk.alarm;
      end

      // ----- outputs and interrupt, event set beats a clear
      top_next.sys_o   = lk.sys_trig;
      top_next.chan_o  = lk.trig;
      top_next.start_o = ev[INT_START];
      top_next.rec_o   = top_next.st != ST_IDLE;
      if (wr && PADDR == OFS_ISTAT) begin
         top_next.istat = top_reg.istat & ~PWDATA[2:0];
      end
      top_next.istat = top_next.istat | ev;
      top_next.irq_o = |(top_next.istat & top_next.imask);
   end

   // ==============================================
   // state register
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         top_reg          <= '0;
         top_reg.st       <= ST_IDLE;
         top_reg.ctrl     <= CTRL_RST;
         top_reg.weight   <= WEIGHT_RST;
         top_reg.key_vote <= KEYV_RST;
         top_reg.ext_vote <= EXTV_RST;
         top_reg.post_len <= POST_RST;
         top_reg.rsel     <= RSEL_RST;
         top_reg.trig_pct <= {NCH{TRIG_PCT_RST}};
         top_reg.det_pct  <= {NCH{DET_PCT_RST}};
         top_reg.ch_vote  <= {NCH{CH_VOTE_RST}};
      end else if (CE) begin
         top_reg <= top_next;
      end
   end

   assign PRDATA      = top_reg.prdata;
   assign PREADY      = top_reg.pready;
   assign PSLVERR     = top_reg.pslverr;
   assign SYS_TRIG    = top_reg.sys_o;
   assign RECORDING   = top_reg.rec_o;
   assign EVENT_START = top_reg.start_o;
   assign CHAN_TRIG   = top_reg.chan_o;
   assign RELAY       = top_reg.relay_o;
   assign STAT_PKT    = top_reg.pkt_o;
   assign PKT_ALARM   = top_reg.pkt_alarm;
   assign IRQ         = top_reg.irq_o;

   // ==============================================
   // checks
   sequence s_votes_drop;
      CE && top_reg.st == ST_TRIG && !lk.sys_trig;
   endsequence

   sequence s_retrigger;
      CE && top_reg.st == ST_POST && lk.sys_trig;
   endsequence

   sequence s_new_alarm;
      CE && top_reg.ctrl[CTRL_BLOCK] && lk.alarm[0] &&
      !top_reg.alarm_d[0];
   endsequence

   a_post_enter: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_votes_drop |=> top_reg.st == ST_POST &&
      top_reg.post_cnt == $past(top_reg.post_len))
      else $error("post interval not started on vote drop");

   a_retrig_extend: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      s_retrigger |=> top_reg.st == ST_TRIG && RECORDING &&
      !EVENT_START)
      else $error("retrigger in post interval split the recording");

   a_event_start: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      CE && top_reg.st == ST_IDLE && lk.sys_trig |=>
      EVENT_START && RECORDING)
      else $error("system trigger did not start a recording");

   a_relay_drive: assert property (@(posedge CLOCK) disable iff (!RST_N)
      CE && lk.alarm[0] && top_reg.rsel[1:0] == 2'b00 |=> RELAY[0])
      else $error("selected relay not driven by alarm");

   a_block_packet: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      s_new_alarm |=> STAT_PKT && PKT_ALARM[0])
      else $error("no status packet on new alarm in block mode");
endmodule

// File: bench/trigger_voting_alarm_logic_tb_top.sv
`timescale 1ns/1ps
module trigger_voting_alarm_logic_tb_top;
   import tva_pkg::*;
   logic        clock = 0, rst_n = 0, ce = 1;
   logic        psel = 0, penable = 0, pwrite = 0, data_valid = 0;
   logic        ext_trig = 0, stat_pkt, sys_trig, recording, event_start;
   logic        pready, pslverr, irq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rnd = 32'd19;
   logic [71:0] trig_data = 0;
   logic [2:0]  chan_trig, pkt_alarm;
   logic [3:0]  relay;
   logic [32:0] expq[$];
   int          fails = 0, cmp_count = 0, ev_cnt = 0, pkt_seen = 0;

   tva_top u_dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TRIG_DATA(trig_data), .DATA_VALID(data_valid), .EXT_TRIG(ext_trig),
      .SYS_TRIG(sys_trig), .RECORDING(recording),
      .EVENT_START(event_start), .CHAN_TRIG(chan_trig), .RELAY(relay),
      .STAT_PKT(stat_pkt), .PKT_ALARM(pkt_alarm), .IRQ(irq));

   always #2 clock = ~clock;

   // ==============================================
   // checking
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp({pslverr, prdata}, expq.pop_front());
      if (event_start === 1'b1) ev_cnt++;
      if (stat_pkt === 1'b1) pkt_seen++;
   end

   task automatic pins(input logic [5:0] e);
      cmp({27'h0, sys_trig, recording, chan_trig, irq}, {27'h0, e});
   endtask

   // ==============================================
   // stimulus
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) expq.push_back(e);
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask

   task automatic smp(input logic [23:0] c0, input logic [23:0] c1);
      rnd = xs(rnd);
      @(posedge clock);
      trig_data <= {7'h0, rnd[16:0], c1, c0};
      data_valid <= 1;
      @(posedge clock);
      data_valid <= 0;
      repeat (5) @(posedge clock);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #300000;
      fails++;
      summarize();
   end

   initial begin
      int e0;
      repeat (4) @(posedge clock);
      rst_n <= 1;
      rd(OFS_CH0, 32'h0202);
      rd(OFS_WEIGHT, 32'h1);
      rd(OFS_KEYV, 32'h1);
      rd(OFS_EXTV, 32'h0);
      rd(OFS_POST, 32'h3e8);
      rd(OFS_RSEL, 32'h24);
      rd(OFS_ISTAT, 32'h0);
      apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0});
      wr(OFS_POST, 32'h3);
      wr(OFS_IMASK, 32'h3);
      wr(OFS_CH0, 32'h0102);
      smp(24'h030000, 24'h0);
      pins(6'b110011);
      e0 = ev_cnt;
      cmp(e0, 33'h1);
      smp(24'h020000, 24'h0);
      pins(6'b110011);
      wr(OFS_ISTAT, 32'h1);
      smp(24'h010000, 24'h0);
      pins(6'b010000);
      smp(24'h0, 24'h0);
      wr(OFS_CTRL, 32'h5);
      repeat (5) @(posedge clock);
      pins(6'b110000);
      cmp(ev_cnt, e0);
      wr(OFS_CTRL, 32'h1);
      repeat (4) smp(24'h0, 24'h0);
      pins(6'b000001);
      rd(OFS_ISTAT, 32'h2);
      wr(OFS_ISTAT, 32'h3);
      wr(OFS_IMASK, 32'h0);
      wr(OFS_CH0 + 12'h14, 32'hff);
      smp(24'h030000, 24'h030000);
      pins(6'b000110);
      wr(OFS_EXTV, 32'h1);
      ext_trig <= 1;
      repeat (6) @(posedge clock);
      pins(6'b110110);
      ext_trig <= 0;
      wr(OFS_CH0 + 12'h8, 32'h0a);
      wr(OFS_CTRL, 32'h3);
      smp(24'h0e0000, 24'h0);
      cmp(relay, 4'b0001);
      cmp({pkt_seen > 0, pkt_alarm}, 4'b1001);
      // disabling clears channel triggers and alarms
      wr(OFS_CTRL, 32'h0);
      repeat (5) @(posedge clock);
      pins(6'b010000);
      cmp(relay, 4'b0000);
      summarize();
   end
endmodule
